// [src/pradv_pkg.sv]
// Constants, field layout and carrier types of the advertising payload framer
package pradv_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_PWR = 8'h00;
  localparam logic [7:0] ADDR_GAIN = 8'h04;
  localparam logic [7:0] ADDR_STAT = 8'h08;
  localparam logic [7:0] ADDR_HANDLE = 8'h0c;
  localparam logic [7:0] ADDR_CHAR = 8'h10;
  localparam logic [7:0] ADDR_ALERT = 8'h14;
  localparam logic [7:0] ADDR_CCCD = 8'h18;
  localparam logic [7:0] ADDR_CTRL = 8'h1c;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int KNOWN_BIT = 8;
  localparam int STAT_OVIMPL_BIT = 3;
  localparam int STAT_TSET_BIT = 4;
  localparam int STAT_OVPIN_BIT = 5;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_DROP_BIT = 1;
  localparam int CTRL_OVP_BIT = 2;
  localparam int IMP_LSB = 5;
  localparam int REBOOT_BIT = 4;
  localparam int OVP_BIT = 3;
  localparam int TSET_BIT = 2;
  localparam int CCCD_NOTIFY_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [8:0] PWR_RST = 9'h000;
  localparam logic [8:0] GAIN_RST = 9'h000;
  localparam logic [5:0] STAT_RST = 6'h00;
  localparam logic [15:0] HANDLE_RST = 16'h0001;
  localparam logic [7:0] ALERT_RST = 8'h00;
  localparam logic [1:0] CCCD_RST = 2'h0;

  // ----------------------------------------------------------------
  // Payload encoding
  // ----------------------------------------------------------------
  localparam logic [7:0] AD_FLAGS_LEN = 8'h02;
  localparam logic [7:0] AD_TYPE_FLAGS = 8'h01;
  localparam logic [7:0] FLAG_LTD_DISC = 8'h01;
  localparam logic [7:0] AD_SD_LEN = 8'h07;
  localparam logic [7:0] AD_TYPE_SD = 8'h16;
  localparam logic [15:0] SVC_UUID = 16'hfffe;
  localparam int PAYLOAD_LEN = 11;
  localparam logic [3:0] LAST_IDX = 4'ha;
  localparam logic [7:0] PWR_OFS_DBM = 8'h14;
  localparam logic [7:0] PWR_MAX_DBM = 8'h32;
  localparam logic [7:0] GAIN_OFS_DBI = 8'h05;
  localparam logic [7:0] GAIN_MAX_DBI = 8'h0b;
  localparam logic [4:0] PWR_UNKNOWN = 5'h1f;
  localparam logic [2:0] GAIN_UNKNOWN = 3'h7;
  localparam logic [2:0] IMP_NEVER = 3'h0;
  localparam logic [2:0] IMP_CAT_MAX = 3'h5;
  localparam logic [15:0] HANDLE_ALERT_OFS = 16'h0006;
  localparam logic [15:0] HANDLE_CCCD_OFS = 16'h0007;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] data;
    logic last;
  } pradv_beat_s;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_SEND = 2'b10
  } pradv_state_e;

endpackage

// [src/pradv_top.sv]
// Advertising payload framer of the power receiver with its register slave
// ----------------------------------------------------------------
// Functional notes
// (RULE1) The payload opens with a flags element that marks limited discoverable mode.
// (RULE2) The two bytes after the service data length and type carry service identifier 0xfffe.
// (RULE3) The primary service handle follows the service identifier directly.
// (RULE4) Characteristic handles run consecutively from the primary service handle plus one; the code starts them at the primary service handle plus 6.
// (RULE5) Service data order is identifier, handle, power/gain byte, status byte.
// (RULE6) The power/gain byte holds the power code in bits 7..3 and the gain code in bits 2..0.
// (RULE7) The power code is the power in dBm less 20, or 11111b when unknown.
// (RULE8) The gain code is the gain in dBi less 5, or 111b when unknown; the code also sends 111b for a known 11 dBi.
// (RULE9) The status byte holds impedance shift in 7..5, reboot in 4, overvoltage in 3, time set in 2.
// (RULE10) The reboot bit is 0 after reset and 1 after a dropped connection with no reset.
// (RULE11) The overvoltage bit shows the condition when implemented and is 0 otherwise.
// (RULE12) The time set bit shows whether the time set command is supported.
// (RULE13) The impedance field gives either never-shifts or a category from 1 to 5.
// (RULE14) Impedance codes are 000 never, 001..101 categories, 110 and 111 reserved.
// (RULE15) The alert value is one octet, default 0, readable and notifiable, descriptor at next handle.
// (RULE16) Reserved bits and fields are sent as zero and ignored on receipt.
// ----------------------------------------------------------------
//
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none

module pradv_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic ovp_pin,
  input wire logic adv_ready,
  output logic adv_valid,
  output pradv_pkg::pradv_beat_s adv_beat,
  output logic alert_notify
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic hreadyout_q;
  logic [31:0] hrdata_q;
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;
  logic [8:0] pwr_q;
  logic [8:0] gain_q;
  logic [5:0] stat_q;
  logic [15:0] handle_q;
  logic [7:0] alert_q;
  logic [1:0] cccd_q;
  logic reboot_q;
  logic alert_notify_q;
  logic [2:0] ovp_sync_q;
  logic ovp_q;
  pradv_pkg::pradv_state_e state_q;
  logic [3:0] cnt_q;
  logic adv_valid_q;
  pradv_pkg::pradv_beat_s beat_q;
  logic [7:0] snap_q [0:pradv_pkg::PAYLOAD_LEN-1];

  logic addr_ph;
  logic wr_go;
  logic [7:0] wdat;
  logic start_req;
  logic drop_req;
  logic [4:0] pwr_code;
  logic [2:0] gain_code;
  logic [2:0] imp_code;
  logic [7:0] status_byte;
  logic [7:0] payload [0:pradv_pkg::PAYLOAD_LEN-1];
  logic [31:0] rd_mux;

  assign addr_ph = hsel & htrans[1] & hready;
  assign wr_go = wr_pend_q;
  assign wdat = hwdata[7:0];
  assign start_req = wr_go && (addr_q == pradv_pkg::ADDR_CTRL) && hwdata[pradv_pkg::CTRL_START_BIT];
  assign drop_req = wr_go && (addr_q == pradv_pkg::ADDR_CTRL) && hwdata[pradv_pkg::CTRL_DROP_BIT];

  // ----------------------------------------------------------------
  // Bus slave: writes without wait, reads with one wait state
  // ----------------------------------------------------------------
  // The wait on reads lets a write in the previous data phase land first
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
      hreadyout_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
    end else begin
      wr_pend_q <= addr_ph & hwrite;
      if (addr_ph) begin
        addr_q <= haddr[7:0];
      end
      if (addr_ph && !hwrite) begin
        rd_pend_q <= 1'b1;
        hreadyout_q <= 1'b0;
      end else if (rd_pend_q) begin
        rd_pend_q <= 1'b0;
        hreadyout_q <= 1'b1;
        hrdata_q <= rd_mux;
      end
    end
  end

  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_q == pradv_pkg::ADDR_PWR) begin
      rd_mux[8:0] = pwr_q;
    end else if (addr_q == pradv_pkg::ADDR_GAIN) begin
      rd_mux[8:0] = gain_q;
    end else if (addr_q == pradv_pkg::ADDR_STAT) begin
      rd_mux[7:0] = {2'h0, stat_q};
    end else if (addr_q == pradv_pkg::ADDR_HANDLE) begin
      rd_mux[15:0] = handle_q;
    end else if (addr_q == pradv_pkg::ADDR_CHAR) begin
      rd_mux = {handle_q + pradv_pkg::HANDLE_CCCD_OFS, handle_q + pradv_pkg::HANDLE_ALERT_OFS}; // RULE4
    end else if (addr_q == pradv_pkg::ADDR_ALERT) begin
      rd_mux[7:0] = alert_q; // RULE15
    end else if (addr_q == pradv_pkg::ADDR_CCCD) begin
      rd_mux[1:0] = cccd_q;
    end else if (addr_q == pradv_pkg::ADDR_CTRL) begin
      rd_mux[2:0] = {ovp_q, reboot_q, adv_valid_q};
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_q <= pradv_pkg::PWR_RST;
      gain_q <= pradv_pkg::GAIN_RST;
      stat_q <= pradv_pkg::STAT_RST;
      handle_q <= pradv_pkg::HANDLE_RST;
      cccd_q <= pradv_pkg::CCCD_RST;
    end else if (wr_go) begin
      if (addr_q == pradv_pkg::ADDR_PWR) begin
        pwr_q <= hwdata[8:0];
      end else if (addr_q == pradv_pkg::ADDR_GAIN) begin
        gain_q <= hwdata[8:0];
      end else if (addr_q == pradv_pkg::ADDR_STAT) begin
        stat_q <= hwdata[5:0];
      end else if (addr_q == pradv_pkg::ADDR_HANDLE) begin
        handle_q <= hwdata[15:0];
      end else if (addr_q == pradv_pkg::ADDR_CCCD) begin
        cccd_q <= hwdata[1:0];
      end
    end
  end

  // Alert value; a write notifies the peer when notification is enabled
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      alert_q <= pradv_pkg::ALERT_RST; // RULE15
      alert_notify_q <= 1'b0;
    end else begin
      alert_notify_q <= 1'b0;
      if (wr_go && (addr_q == pradv_pkg::ADDR_ALERT)) begin
        alert_q <= wdat; // RULE15
        alert_notify_q <= cccd_q[pradv_pkg::CCCD_NOTIFY_BIT];
      end
    end
  end

  // Only a reset clears it, so a drop can never be lost to a clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reboot_q <= 1'b0; // RULE10
    end else if (drop_req) begin
      reboot_q <= 1'b1; // RULE10
    end
  end

  // ----------------------------------------------------------------
  // Overvoltage pin synchroniser and agreement filter
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovp_sync_q <= 3'h0;
      ovp_q <= 1'b0;
    end else begin
      ovp_sync_q <= {ovp_sync_q[1:0], ovp_pin};
      if (ovp_sync_q[1] == ovp_sync_q[2]) begin
        ovp_q <= ovp_sync_q[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Field encoding
  // ----------------------------------------------------------------
  always_comb begin
    pwr_code = pradv_pkg::PWR_UNKNOWN; // RULE7
    gain_code = pradv_pkg::GAIN_UNKNOWN; // RULE8
    // Out-of-range figures cannot be coded, so they go out as unknown
    if (pwr_q[pradv_pkg::KNOWN_BIT] && pwr_q[7:0] >= pradv_pkg::PWR_OFS_DBM && pwr_q[7:0] < pradv_pkg::PWR_MAX_DBM + 8'h01) begin
      pwr_code = 5'(pwr_q[7:0] - pradv_pkg::PWR_OFS_DBM); // RULE7
    end
    if (gain_q[pradv_pkg::KNOWN_BIT] && gain_q[7:0] >= pradv_pkg::GAIN_OFS_DBI && gain_q[7:0] < pradv_pkg::GAIN_MAX_DBI) begin
      gain_code = 3'(gain_q[7:0] - pradv_pkg::GAIN_OFS_DBI); // RULE8
    end
    // Reserved categories are never sent
    imp_code = (stat_q[2:0] > pradv_pkg::IMP_CAT_MAX) ? pradv_pkg::IMP_NEVER : stat_q[2:0]; // RULE13 RULE14
    status_byte = 8'h00; // RULE16
    status_byte[pradv_pkg::IMP_LSB +: 3] = imp_code; // RULE9
    status_byte[pradv_pkg::REBOOT_BIT] = reboot_q; // RULE10
    status_byte[pradv_pkg::OVP_BIT] = stat_q[pradv_pkg::STAT_OVIMPL_BIT] & ovp_q; // RULE11
    status_byte[pradv_pkg::TSET_BIT] = stat_q[pradv_pkg::STAT_TSET_BIT]; // RULE12
  end

  assign payload[0] = pradv_pkg::AD_FLAGS_LEN; // RULE1
  assign payload[1] = pradv_pkg::AD_TYPE_FLAGS;
  assign payload[2] = pradv_pkg::FLAG_LTD_DISC;
  assign payload[3] = pradv_pkg::AD_SD_LEN;
  assign payload[4] = pradv_pkg::AD_TYPE_SD;
  assign payload[5] = pradv_pkg::SVC_UUID[7:0]; // RULE2
  assign payload[6] = pradv_pkg::SVC_UUID[15:8];
  assign payload[7] = handle_q[7:0]; // RULE3
  assign payload[8] = handle_q[15:8];
  assign payload[9] = {pwr_code, gain_code}; // RULE5 RULE6
  assign payload[10] = status_byte; // RULE5

  // ----------------------------------------------------------------
  // Byte stream; the payload is frozen at start so a frame never mixes settings
  // ----------------------------------------------------------------
  generate
    for (genvar i = 0; i < pradv_pkg::PAYLOAD_LEN; i++) begin : g_snap
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          snap_q[i] <= 8'h00;
        end else if (start_req && state_q == pradv_pkg::ST_IDLE) begin
          snap_q[i] <= payload[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= pradv_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      adv_valid_q <= 1'b0;
      beat_q <= '0;
    end else begin
      case (state_q)
        pradv_pkg::ST_IDLE: begin
          if (start_req) begin
            state_q <= pradv_pkg::ST_SEND;
            cnt_q <= 4'h0;
            adv_valid_q <= 1'b1;
            beat_q <= '{data: payload[0], last: 1'b0};
          end
        end
        pradv_pkg::ST_SEND: begin
          if (adv_ready) begin
            if (cnt_q == pradv_pkg::LAST_IDX) begin
              state_q <= pradv_pkg::ST_IDLE;
              adv_valid_q <= 1'b0;
              beat_q <= '0;
            end else begin
              cnt_q <= cnt_q + 4'h1;
              beat_q <= '{data: snap_q[cnt_q + 4'h1], last: (cnt_q + 4'h1 == pradv_pkg::LAST_IDX)}; // RULE5
            end
          end
        end
        default: begin
          state_q <= pradv_pkg::ST_IDLE;
          adv_valid_q <= 1'b0;
        end
      endcase
    end
  end

  assign hreadyout = hreadyout_q;
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;
  assign adv_valid = adv_valid_q;
  assign adv_beat = beat_q;
  assign alert_notify = alert_notify_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  property p_flags_first;
    adv_valid && cnt_q == 4'h2 |-> beat_q.data == pradv_pkg::FLAG_LTD_DISC && snap_q[1] == pradv_pkg::AD_TYPE_FLAGS;
  endproperty
  a_flags_first: assert property (p_flags_first) else $error("flags element wrong"); // RULE1

  property p_uuid;
    adv_valid && cnt_q == 4'h5 && adv_ready |=> beat_q.data == 8'hff;
  endproperty
  a_uuid: assert property (p_uuid) else $error("service identifier high byte wrong"); // RULE2

  property p_handle;
    $rose(adv_valid) |-> snap_q[7] == handle_q[7:0] && snap_q[8] == handle_q[15:8];
  endproperty
  a_handle: assert property (p_handle) else $error("handle not captured"); // RULE3

  property p_char_handles;
    addr_ph && !hwrite && haddr[7:0] == pradv_pkg::ADDR_CHAR && !wr_pend_q
      ##2 hreadyout |-> hrdata[31:16] == hrdata[15:0] + 16'h0001 && hrdata[15:0] == handle_q + 16'h0006;
  endproperty
  a_char_handles: assert property (p_char_handles) else $error("characteristic handles not sequential"); // RULE4

  property p_last;
    adv_valid && adv_beat.last |-> cnt_q == pradv_pkg::LAST_IDX;
  endproperty
  a_last: assert property (p_last) else $error("last marked on wrong byte"); // RULE5

  property p_pwr_unknown;
    !pwr_q[pradv_pkg::KNOWN_BIT] |-> payload[9][7:3] == 5'h1f;
  endproperty
  a_pwr_unknown: assert property (p_pwr_unknown) else $error("unknown power not all ones"); // RULE7

  property p_pwr_code;
    pwr_q == 9'h11f |-> payload[9][7:3] == 5'h0b;
  endproperty
  a_pwr_code: assert property (p_pwr_code) else $error("power offset wrong"); // RULE7

  property p_gain;
    !gain_q[pradv_pkg::KNOWN_BIT] |-> payload[9][2:0] == 3'h7;
  endproperty
  a_gain: assert property (p_gain) else $error("unknown gain not all ones"); // RULE8

  property p_reserved;
    payload[10][1:0] == 2'h0 && payload[10][7:5] <= 3'h5;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved status content sent"); // RULE16

  property p_reboot;
    drop_req |=> payload[10][4] ##1 payload[10][4];
  endproperty
  a_reboot: assert property (p_reboot) else $error("reboot bit not set after drop"); // RULE10

  property p_ovp;
    !stat_q[pradv_pkg::STAT_OVIMPL_BIT] |-> !payload[10][3];
  endproperty
  a_ovp: assert property (p_ovp) else $error("overvoltage bit set while not implemented"); // RULE11

  property p_tset;
    payload[10][2] == stat_q[pradv_pkg::STAT_TSET_BIT];
  endproperty
  a_tset: assert property (p_tset) else $error("time set support bit wrong"); // RULE12

  property p_imp;
    stat_q[2:0] <= 3'h5 |-> payload[10][7:5] == stat_q[2:0];
  endproperty
  a_imp: assert property (p_imp) else $error("impedance category not passed"); // RULE14

  property p_frame;
    adv_valid && !adv_ready |=> adv_valid && $stable(beat_q);
  endproperty
  a_frame: assert property (p_frame) else $error("offered byte changed before acceptance"); // RULE5
  c_frame: cover property (adv_valid && adv_beat.last && adv_ready);
  c_notify: cover property (alert_notify);
  c_stall: cover property (adv_valid && !adv_ready ##1 adv_valid && adv_ready);
  c_reboot: cover property (drop_req ##[1:20] $rose(adv_valid));

endmodule

`default_nettype wire

// [testbench/pradv_sink.sv]
// Payload sink model standing in for the scanning power transmitter
`timescale 1ns/1ps
`default_nettype none

module pradv_sink (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic slow,
  input wire logic clr,
  input wire logic adv_valid,
  input wire pradv_pkg::pradv_beat_s adv_beat,
  output logic adv_ready,
  output logic [87:0] frame,
  output logic [7:0] cnt,
  output logic [7:0] last_at
);
  // ----------------------------------------------------------------
  // Flow control
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      adv_ready <= 1'b0;
    end else begin
      // Slow mode stalls every other cycle, even with a byte offered
      adv_ready <= slow ? ~adv_ready : 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Capture
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      frame <= 88'h0;
      cnt <= 8'h00;
      last_at <= 8'h00;
    end else if (clr) begin
      frame <= 88'h0;
      cnt <= 8'h00;
      last_at <= 8'h00;
    end else if (adv_valid && adv_ready) begin
      // Raw bytes only; no field decoding, so reserved bits change nothing here
      frame <= {frame[79:0], adv_beat.data};
      cnt <= cnt + 8'h01;
      if (adv_beat.last) begin
        last_at <= cnt + 8'h01;
      end
    end
  end
endmodule

`default_nettype wire

// [testbench/pradv_tb_top.sv]
// Self-checking testbench of the advertising payload framer
`timescale 1ns/1ps
`default_nettype none

module pradv_tb_top;
  typedef struct packed {
    logic [8:0] pwr;
    logic [8:0] gain;
    logic [5:0] stat;
    logic [15:0] hdl;
    logic [7:0] pg;
    logic [7:0] st;
  } pradv_row_s;

  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, ovp_pin, slow, clr;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic hreadyout, hresp, adv_valid, adv_ready, alert_notify;
  pradv_pkg::pradv_beat_s adv_beat;
  logic [87:0] frame;
  logic [7:0] cnt, last_at;
  logic [31:0] x;
  int fails = 0;
  int cmp_count = 0;
  int alerts = 0;
  int a0;
  logic [7:0] ra [9] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20};
  logic [31:0] rv [9] = '{32'h0, 32'h0, 32'h0, 32'h1, 32'h00080007, 32'h0, 32'h0, 32'h0, 32'h0};
  pradv_row_s rows [7] = '{
    '{9'h000, 9'h000, 6'h00, 16'h0101, 8'hff, 8'h00},
    '{9'h114, 9'h105, 6'h11, 16'habcd, 8'h00, 8'h24},
    '{9'h132, 9'h10a, 6'h0a, 16'h1234, 8'hf5, 8'h40},
    '{9'h133, 9'h00b, 6'h13, 16'h0002, 8'hff, 8'h64},
    '{9'h113, 9'h104, 6'h04, 16'h0010, 8'hff, 8'h80},
    '{9'h11f, 9'h108, 6'h05, 16'h8000, 8'h5b, 8'ha0},
    '{9'h11e, 9'h00a, 6'h17, 16'h0fff, 8'h57, 8'h04}};

  always #12.5 hclk = ~hclk;

  always @(posedge hclk) begin
    if (alert_notify === 1'b1) begin
      alerts <= alerts + 1;
    end
  end

  pradv_top pradv_top_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .ovp_pin(ovp_pin), .adv_ready(adv_ready), .adv_valid(adv_valid),
    .adv_beat(adv_beat), .alert_notify(alert_notify));

  pradv_sink pradv_sink_i (
    .hclk(hclk), .hresetn(hresetn), .slow(slow), .clr(clr), .adv_valid(adv_valid),
    .adv_beat(adv_beat), .adv_ready(adv_ready), .frame(frame), .cnt(cnt), .last_at(last_at));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic finish_test();
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [87:0] got, input logic [87:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge hclk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        fails++;
        finish_test();
      end
      @(posedge hclk);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] y;
    bus(1'b1, a, d, y);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] y;
    bus(1'b0, a, 32'h0, y);
    check({hresp, y}, {1'b0, exp});
  endtask

  // Second start lands mid-frame and must not add bytes
  task automatic run_frame(input logic [87:0] exp);
    int n;
    n = 0;
    @(posedge hclk);
    clr <= 1'b1;
    @(posedge hclk);
    clr <= 1'b0;
    wr(pradv_pkg::ADDR_CTRL, 32'h1);
    wr(pradv_pkg::ADDR_CTRL, 32'h1);
    while (cnt !== 8'h0b) begin
      n++;
      if (n > 300) begin
        fails++;
        finish_test();
      end
      @(posedge hclk);
    end
    repeat (20) @(posedge hclk);
    check(frame, exp);
    check(cnt, 8'h0b);
    check(last_at, 8'h0b);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ovp_pin = 1'b0;
    slow = 1'b0;
    clr = 1'b0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd_chk(ra[i], rv[i]);
    end
    wr(pradv_pkg::ADDR_CHAR, 32'hffffffff);
    rd_chk(pradv_pkg::ADDR_CHAR, 32'h00080007);
    wr(8'h20, 32'h12345678);
    rd_chk(8'h20, 32'h0);
    for (int i = 0; i < 7; i++) begin
      slow <= i[0];
      wr(pradv_pkg::ADDR_PWR, {23'h0, rows[i].pwr});
      wr(pradv_pkg::ADDR_GAIN, {23'h0, rows[i].gain});
      wr(pradv_pkg::ADDR_STAT, {26'h0, rows[i].stat});
      wr(pradv_pkg::ADDR_HANDLE, {16'h0, rows[i].hdl});
      rd_chk(pradv_pkg::ADDR_CHAR, {rows[i].hdl + 16'h0007, rows[i].hdl + 16'h0006});
      run_frame({56'h0201010716feff, rows[i].hdl[7:0], rows[i].hdl[15:8], rows[i].pg, rows[i].st});
    end
    // Overvoltage shown only while implemented; filter latency is polled
    ovp_pin <= 1'b1;
    wr(pradv_pkg::ADDR_STAT, 32'h08);
    for (int n = 0; n < 20 && x[2] !== 1'b1; n++) begin
      bus(1'b0, pradv_pkg::ADDR_CTRL, 32'h0, x);
    end
    check(x[2:0], 3'b100);
    run_frame({56'h0201010716feff, 16'hff0f, 8'h57, 8'h08});
    wr(pradv_pkg::ADDR_STAT, 32'h00);
    run_frame({56'h0201010716feff, 16'hff0f, 8'h57, 8'h00});
    ovp_pin <= 1'b0;
    wr(pradv_pkg::ADDR_CTRL, 32'h2);
    bus(1'b0, pradv_pkg::ADDR_CTRL, 32'h0, x);
    check(x[1:0], 2'b10);
    run_frame({56'h0201010716feff, 16'hff0f, 8'h57, 8'h10});
    wr(pradv_pkg::ADDR_CCCD, 32'h0);
    a0 = alerts;
    wr(pradv_pkg::ADDR_ALERT, 32'h5a);
    repeat (3) @(posedge hclk);
    check(alerts - a0, 0);
    wr(pradv_pkg::ADDR_CCCD, 32'h1);
    wr(pradv_pkg::ADDR_ALERT, 32'ha5);
    repeat (3) @(posedge hclk);
    check(alerts - a0, 1);
    rd_chk(pradv_pkg::ADDR_ALERT, 32'ha5);
    rd_chk(pradv_pkg::ADDR_CCCD, 32'h1);
    // Second reset in mid-run must clear reboot and restore defaults
    @(posedge hclk);
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk(pradv_pkg::ADDR_CTRL, 32'h0);
    run_frame({56'h0201010716feff, 16'h0100, 8'hff, 8'h00});
    finish_test();
  end
endmodule

`default_nettype wire
